// file: rtl/qdc_defs.vh
/*
 * Constants for the quad converter serial control block: serial frame layout,
 * command fields, register offsets and reset values.
 * Assumes it is included by bare name from the design files under rtl/.
 */
`ifndef QDC_DEFS_VH
`define QDC_DEFS_VH

// Serial frame.
`define QDC_FRAME_BITS      24
`define QDC_CNT_W           6
`define QDC_SCLK_MAX_MHZ    30
`define QDC_SYNC_STAGES     2

// Command word fields.
`define QDC_CMD_RW_BIT      23
`define QDC_CMD_REG_HI      21
`define QDC_CMD_REG_LO      19
`define QDC_CMD_CH_HI       17
`define QDC_CMD_CH_LO       16
`define QDC_CMD_DATA_HI     15
`define QDC_CMD_DATA_LO     0

// Register select codes inside a command.
`define QDC_SEL_PORT        3'h1
`define QDC_SEL_DATA        3'h2

// Port configuration fields in a port command.
`define QDC_PORT_DIR_LO     0
`define QDC_PORT_VAL_LO     2

// Values.
`define QDC_CLEAR_CODE      16'h0000
`define QDC_ZERO_VOLT_CODE  16'h8000
`define QDC_MSB_FLIP        16'h8000

// Bus register byte offsets.
`define QDC_OFF_MODE        8'h00
`define QDC_OFF_STATUS      8'h04
`define QDC_OFF_PORT        8'h08
`define QDC_OFF_OUT0        8'h10
`define QDC_OFF_IN0         8'h20
`define QDC_MODE_RESET      32'h0000_0000

// Bus responses.
`define QDC_RESP_OKAY       2'h0
`define QDC_RESP_SLVERR     2'h2

`endif

// file: rtl/qdc_serial_ctrl.v
/*
 * Digital control front end of a quad bipolar converter: framed serial port,
 * staged and output data registers, load strobe, clear, output clamp,
 * supply monitor output, two-bit digital port and an AXI4-Lite view.
 * Assumes all pins are asynchronous to clk and the serial clock runs far
 * below clk, so every pin is sampled through qdc_sync.
 */
// Notes on behaviour
// - Frame select is active low; bits are accepted only while it is low.
// - Each serial bit shifts in on the falling serial clock edge; 30 MHz max.
// - In daisy-chain or readback mode serial output carries shifted-out bits.
// - Falling edge on clear input loads the output data registers with zero.
// - With load strobe low, addressed output register updates at frame end.
// - With load strobe high, only input register updates; output waits.
// - Falling load strobe moves all pending input registers out together.
// - Two port pins, serially configured in or out, readable, pulled up while inputs.
// - Reset output follows the internal supply monitor state.
// - Low clamp input forces outputs to zero volts, registers untouched.
// - Clear input is pulled up; floating means high and no clear.
// - Coding select high means offset binary, low means twos complement.
`timescale 1ns/1ps
`include "qdc_defs.vh"
module qdc_serial_ctrl (
    input  wire        clk,              // System clock, 100 MHz.
    input  wire        rst,              // Synchronous reset, active high.
    input  wire        frameSelN,        // Serial frame select, active low.
    input  wire        sclk,             // Serial clock from the host.
    input  wire        serialIn,         // Serial data in.
    output reg         serialOut,        // Serial data out.
    input  wire        outputLoadN,      // Output load strobe, active low.
    input  wire        zeroOutputsN,     // Clear input, falling edge acts.
    input  wire        outputClampInN,   // Output clamp input, active low.
    input  wire        codingSelect,     // High offset binary, low twos complement.
    input  wire        supplyGood,       // Internal supply monitor level.
    output reg         supplyMonitorOut, // Supply monitor state to the system.
    input  wire        portBit0In,       // Port pin 0 level.
    output reg         portBit0Out,      // Port pin 0 drive value.
    output reg         portBit0OeN,      // Port pin 0 enable, low drives.
    input  wire        portBit1In,       // Port pin 1 level.
    output reg         portBit1Out,      // Port pin 1 drive value.
    output reg         portBit1OeN,      // Port pin 1 enable, low drives.
    output reg  [1:0]  portPullUpEn,     // Weak pull-up enable per pin.
    output reg  [63:0] dacCodes,         // Offset binary codes, channel 0 low.
    output reg         outputsClamped,   // High while outputs are clamped.
    input  wire [7:0]  s_axi_awaddr,     // Write address.
    input  wire        s_axi_awvalid,    // Write address valid.
    output reg         s_axi_awready,    // Write address ready.
    input  wire [31:0] s_axi_wdata,      // Write data.
    input  wire [3:0]  s_axi_wstrb,      // Write byte strobes.
    input  wire        s_axi_wvalid,     // Write data valid.
    output reg         s_axi_wready,     // Write data ready.
    output reg  [1:0]  s_axi_bresp,      // Write response.
    output reg         s_axi_bvalid,     // Write response valid.
    input  wire        s_axi_bready,     // Write response ready.
    input  wire [7:0]  s_axi_araddr,     // Read address.
    input  wire        s_axi_arvalid,    // Read address valid.
    output reg         s_axi_arready,    // Read address ready.
    output reg  [31:0] s_axi_rdata,      // Read data.
    output reg  [1:0]  s_axi_rresp,      // Read response.
    output reg         s_axi_rvalid,     // Read data valid.
    input  wire        s_axi_rready      // Read data ready.
);

    wire [9:0]  pinSync;
    wire        fsS, sclkS, sdiS, ldS, clrS, clampS, codeS, supS, pin0S, pin1S;
    reg         fs_q, sclk_q, ld_q, clr_q;
    reg  [23:0] shift_q;
    reg  [5:0]  bitCnt_q;
    reg         readbackArm_q;
    reg  [15:0] inReg_q   [0:3];
    reg  [15:0] dacReg_q  [0:3];
    reg  [3:0]  pending_q;
    reg  [1:0]  portDir_q;
    reg  [1:0]  portVal_q;
    reg  [31:0] mode_q;
    reg  [7:0]  awAddr_q;
    reg  [31:0] wData_q;
    reg  [3:0]  wStrb_q;
    reg         awHeld_q, wHeld_q;
    integer     i, k;

    wire frameActive = ~fsS;
    wire sclkFall    = sclk_q & ~sclkS;
    wire sclkRise    = ~sclk_q & sclkS;
    wire frameStart  = fs_q & ~fsS;
    wire frameEnd    = ~fs_q & fsS;
    wire loadFall    = ld_q & ~ldS;
    wire clearFall   = clr_q & ~clrS;
    wire daisyEn     = mode_q[0];
    wire frameFull   = (bitCnt_q >= `QDC_FRAME_BITS);
    wire cmdRead     = shift_q[`QDC_CMD_RW_BIT];
    wire [2:0]  cmdSel  = shift_q[`QDC_CMD_REG_HI:`QDC_CMD_REG_LO];
    wire [1:0]  cmdCh   = shift_q[`QDC_CMD_CH_HI:`QDC_CMD_CH_LO];
    wire [15:0] cmdData = shift_q[`QDC_CMD_DATA_HI:`QDC_CMD_DATA_LO];
    wire [1:0]  pinLevel = {pin1S, pin0S};
    wire [7:0]  portWord = {2'b00, pinLevel, portVal_q, portDir_q};

    // Every pin passes two flops; the six low bits, frame select to clamp, reset high so a
    // floating or undriven input never looks like a falling edge.
    qdc_sync #(
        .WIDTH (10),
        .INIT  (10'h03f)
    ) pinSyncInst (
        .clk     (clk),
        .rst     (rst),
        .asyncIn ({portBit1In, portBit0In, supplyGood, codingSelect, outputClampInN,
                   zeroOutputsN, outputLoadN, serialIn, sclk, frameSelN}),
        .syncOut (pinSync)
    );
    assign {pin1S, pin0S, supS, codeS, clampS, clrS, ldS, sdiS, sclkS, fsS} = pinSync;

    // Maps a bus byte address to a register slot; bit 4 flags a valid slot.
    function [4:0] decodeAddr;
        input [7:0] addr;
        begin
            if (addr == `QDC_OFF_MODE)
                decodeAddr = 5'h10;
            else if (addr == `QDC_OFF_STATUS)
                decodeAddr = 5'h11;
            else if (addr == `QDC_OFF_PORT)
                decodeAddr = 5'h12;
            else if (addr[7:4] == 4'h1 && addr[1:0] == 2'b00)
                decodeAddr = {3'b101, addr[3:2]};
            else if (addr[7:4] == 4'h2 && addr[1:0] == 2'b00)
                decodeAddr = {3'b110, addr[3:2]};
            else
                decodeAddr = 5'h00;
        end
    endfunction

    // Converts a stored word into the offset binary code the converter takes.
    function [15:0] toOffsetBinary;
        input [15:0] word;
        input        offsetMode;
        begin
            toOffsetBinary = offsetMode ? word : (word ^ `QDC_MSB_FLIP);
        end
    endfunction

    // Edge detection history, all on synchronised copies only.
    always @(posedge clk) begin
        if (rst) begin
            fs_q   <= 1'b1;
            sclk_q <= 1'b1;
            ld_q   <= 1'b1;
            clr_q  <= 1'b1;
        end else begin
            fs_q   <= fsS;
            sclk_q <= sclkS;
            ld_q   <= ldS;
            clr_q  <= clrS;
        end
    end

    // Shift register and bit counter. The counter saturates so a long
    // daisy-chain frame still leaves the last 24 bits as the command.
    always @(posedge clk) begin
        if (rst) begin
            shift_q  <= 24'h000000;
            bitCnt_q <= 6'h00;
        end else if (frameStart) begin
            bitCnt_q <= 6'h00;
        end else if (frameActive && sclkFall) begin
            shift_q <= {shift_q[22:0], sdiS};
            if (bitCnt_q != 6'h3f)
                bitCnt_q <= bitCnt_q + 6'h01;
        end else if (frameEnd && frameFull && cmdRead) begin
            // A read command leaves its answer in the shift register for the
            // next frame to clock out.
            if (cmdSel == `QDC_SEL_DATA)
                shift_q <= {8'h00, inReg_q[cmdCh]};
            else if (cmdSel == `QDC_SEL_PORT)
                shift_q <= {16'h0000, portWord};
            else
                shift_q <= 24'h000000;
        end
    end

    // Serial output changes on rising serial clock edges so the host can
    // sample it on the following falling edge; idle low outside the modes.
    always @(posedge clk) begin
        if (rst) begin
            serialOut     <= 1'b0;
            readbackArm_q <= 1'b0;
        end else begin
            if (frameEnd && frameFull)
                readbackArm_q <= cmdRead;
            else if (frameEnd)
                readbackArm_q <= 1'b0;
            if (!(daisyEn || readbackArm_q))
                serialOut <= 1'b0;
            else if (frameStart || (frameActive && sclkRise))
                serialOut <= shift_q[23];
        end
    end

    // Input and output data registers. Clear has the last word on the
    // output registers; a same-cycle frame end with the load strobe high still leaves a flag pending.
    always @(posedge clk) begin
        if (rst) begin
            for (i = 0; i < 4; i = i + 1) begin
                inReg_q[i]  <= `QDC_CLEAR_CODE;
                dacReg_q[i] <= `QDC_CLEAR_CODE;
            end
            pending_q <= 4'h0;
        end else begin
            if (loadFall) begin
                for (i = 0; i < 4; i = i + 1) begin
                    if (pending_q[i])
                        dacReg_q[i] <= inReg_q[i];
                end
                pending_q <= 4'h0;
            end
            if (frameEnd && frameFull && !cmdRead && cmdSel == `QDC_SEL_DATA) begin
                inReg_q[cmdCh] <= cmdData;
                if (!ldS)
                    dacReg_q[cmdCh] <= cmdData;
                else
                    pending_q[cmdCh] <= 1'b1;
            end
            if (clearFall) begin
                for (i = 0; i < 4; i = i + 1)
                    dacReg_q[i] <= `QDC_CLEAR_CODE;
            end
        end
    end

    // Digital port configuration from serial write commands.
    always @(posedge clk) begin
        if (rst) begin
            portDir_q <= 2'b00;
            portVal_q <= 2'b00;
        end else if (frameEnd && frameFull && !cmdRead && cmdSel == `QDC_SEL_PORT) begin
            portDir_q <= cmdData[`QDC_PORT_DIR_LO+1:`QDC_PORT_DIR_LO];
            portVal_q <= cmdData[`QDC_PORT_VAL_LO+1:`QDC_PORT_VAL_LO];
        end
    end

    // Pin drivers and converter codes, each straight from a flop. The clamp
    // only masks the codes, so the data registers keep their contents.
    always @(posedge clk) begin
        if (rst) begin
            portBit0Out      <= 1'b0;
            portBit1Out      <= 1'b0;
            portBit0OeN      <= 1'b1;
            portBit1OeN      <= 1'b1;
            portPullUpEn     <= 2'b11;
            supplyMonitorOut <= 1'b0;
            outputsClamped   <= 1'b1;
            dacCodes         <= {4{`QDC_ZERO_VOLT_CODE}};
        end else begin
            portBit0Out      <= portVal_q[0];
            portBit1Out      <= portVal_q[1];
            portBit0OeN      <= ~portDir_q[0];
            portBit1OeN      <= ~portDir_q[1];
            portPullUpEn     <= ~portDir_q;
            supplyMonitorOut <= supS;
            outputsClamped   <= ~clampS;
            for (k = 0; k < 4; k = k + 1) begin
                if (!clampS)
                    dacCodes[k*16 +: 16] <= `QDC_ZERO_VOLT_CODE;
                else
                    dacCodes[k*16 +: 16] <= toOffsetBinary(dacReg_q[k], codeS);
            end
        end
    end

    // Bus write side: address and data are caught in either order and the
    // response follows once both are held. One write at a time.
    always @(posedge clk) begin
        if (rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `QDC_RESP_OKAY;
            awHeld_q      <= 1'b0;
            wHeld_q       <= 1'b0;
            awAddr_q      <= 8'h00;
            wData_q       <= 32'h0000_0000;
            wStrb_q       <= 4'h0;
            mode_q        <= `QDC_MODE_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awAddr_q      <= s_axi_awaddr;
                awHeld_q      <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wData_q      <= s_axi_wdata;
                wStrb_q      <= s_axi_wstrb;
                wHeld_q      <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (awHeld_q && wHeld_q && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                awHeld_q     <= 1'b0;
                wHeld_q      <= 1'b0;
                if (decodeAddr(awAddr_q) == 5'h10) begin
                    s_axi_bresp <= `QDC_RESP_OKAY;
                    if (wStrb_q[0])
                        mode_q[0] <= wData_q[0];
                end else if (decodeAddr(awAddr_q) != 5'h00) begin
                    s_axi_bresp <= `QDC_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `QDC_RESP_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Bus read side: the answer follows the accepted address by one cycle.
    always @(posedge clk) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `QDC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `QDC_RESP_OKAY;
            case (decodeAddr(s_axi_araddr))
                5'h10: s_axi_rdata <= {31'h0, mode_q[0]};
                5'h11: s_axi_rdata <= {20'h0, supS, codeS, ~clampS, readbackArm_q,
                                       frameActive, 3'h0, pending_q};
                5'h12: s_axi_rdata <= {24'h0, portWord};
                5'h14: s_axi_rdata <= {16'h0, dacReg_q[0]};
                5'h15: s_axi_rdata <= {16'h0, dacReg_q[1]};
                5'h16: s_axi_rdata <= {16'h0, dacReg_q[2]};
                5'h17: s_axi_rdata <= {16'h0, dacReg_q[3]};
                5'h18: s_axi_rdata <= {16'h0, inReg_q[0]};
                5'h19: s_axi_rdata <= {16'h0, inReg_q[1]};
                5'h1a: s_axi_rdata <= {16'h0, inReg_q[2]};
                5'h1b: s_axi_rdata <= {16'h0, inReg_q[3]};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `QDC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule

// file: rtl/qdc_sync.v
/*
 * Two-stage synchroniser for a group of independent level inputs.
 * Assumes each bit is a slow level or a clock much slower than clk.
 */
`timescale 1ns/1ps
module qdc_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    input  wire             clk,      // System clock.
    input  wire             rst,      // Synchronous reset, active high.
    input  wire [WIDTH-1:0] asyncIn,  // Inputs from another domain.
    output reg  [WIDTH-1:0] syncOut   // Synchronised levels.
);

    reg [WIDTH-1:0] meta_q;

    // The first stage is read only by the second stage.
    always @(posedge clk) begin
        if (rst) begin
            meta_q  <= INIT;
            syncOut <= INIT;
        end else begin
            meta_q  <= asyncIn;
            syncOut <= meta_q;
        end
    end

endmodule

// file: verification/qdc_host_model.sv
/*
 * Host serial port model: frames of up to 24 bits, MSB first, and capture of the serial output.
 * Assumes clk is the bench clock; the serial clock has an 80 ns period and idles high.
 */
`timescale 1ns/1ps
module qdc_host_model (
    input  wire         clk,       // Bench clock.
    input  wire         serialOut, // Device serial output.
    output logic        frameSelN, // Frame select, active low.
    output logic        sclk,      // Serial clock, still between frames.
    output logic        serialIn,  // Serial data to the device.
    output logic [23:0] rxWord     // Bits seen at the falling edges.
);
    // Idle levels at time zero.
    initial begin
        frameSelN = 1'b1;
        sclk = 1'b1;
        serialIn = 1'b0;
        rxWord = 24'h0;
    end

    // Data moves with the rising edge, so it has settled long before each fall.
    task automatic xfer(input logic [23:0] w, input int n);
        int i;
        frameSelN <= 1'b0;
        for (i = n - 1; i >= 0; i--) begin
            sclk <= 1'b1;
            serialIn <= w[i];
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
            rxWord <= {rxWord[22:0], serialOut};
            repeat (4) @(posedge clk);
        end
        sclk <= 1'b1;
        repeat (4) @(posedge clk);
        frameSelN <= 1'b1;
        serialIn <= ~serialIn; // A released line must not keep showing the last bit.
        repeat (12) @(posedge clk);
    endtask
endmodule

// file: verification/qdc_serial_ctrl_properties.sv
/*
 * Concurrent checks on the ports of qdc_serial_ctrl.
 * Assumes pin inputs pass a two-flop synchroniser, so effects lag them by a few clocks.
 */
`timescale 1ns/1ps
module qdc_serial_ctrl_properties (
    input wire        clk,              // System clock.
    input wire        rst,              // Synchronous reset.
    input wire        frameSelN,        // Frame select.
    input wire        outputLoadN,      // Load strobe.
    input wire        zeroOutputsN,     // Clear input.
    input wire        outputClampInN,   // Clamp input.
    input wire        codingSelect,     // Coding select.
    input wire        supplyGood,       // Supply level.
    input wire        supplyMonitorOut, // Supply output.
    input wire        portBit0OeN,      // Pin 0 enable.
    input wire        portBit1OeN,      // Pin 1 enable.
    input wire [1:0]  portPullUpEn,     // Pull-ups.
    input wire [63:0] dacCodes,         // Output codes.
    input wire        outputsClamped,   // Clamp flag.
    input wire        s_axi_awvalid,    // Bus.
    input wire        s_axi_awready,    // Bus.
    input wire        s_axi_wvalid,     // Bus.
    input wire        s_axi_wready,     // Bus.
    input wire        s_axi_bvalid,     // Bus.
    input wire        s_axi_arvalid,    // Bus.
    input wire        s_axi_arready,    // Bus.
    input wire        s_axi_rvalid      // Bus.
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_clamp_mid: assert property (outputsClamped |-> dacCodes == {4{16'h8000}})
        else $error("clamped outputs not at mid code");
    a_clamp_pin: assert property ($stable(outputClampInN) [*6] |-> outputsClamped == !outputClampInN)
        else $error("clamp flag does not follow its pin");
    a_supply_follow: assert property ($stable(supplyGood) [*6] |-> supplyMonitorOut == supplyGood)
        else $error("supply output does not follow the monitor");
    a_pullup_input: assert property (portPullUpEn == {portBit1OeN, portBit0OeN})
        else $error("pull-up not matching pin direction");
    a_outputs_quiet: assert property ((frameSelN && outputLoadN && zeroOutputsN && $stable(codingSelect)
        && $stable(outputClampInN)) [*8] |-> $stable(dacCodes))
        else $error("outputs moved with no cause");
    a_clear_zero: assert property ($fell(zeroOutputsN) && codingSelect && !outputsClamped
        |-> ##[2:8] dacCodes == 64'h0)
        else $error("clear did not zero the outputs");
    a_coding_flip: assert property ($changed(codingSelect) && !outputsClamped && outputClampInN
        |-> ##5 (dacCodes[15:0] ^ $past(dacCodes[15:0], 5)) == 16'h8000)
        else $error("coding change did not flip the sign bit");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:3] s_axi_bvalid)
        else $error("write response missing");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data missing");
endmodule
bind qdc_serial_ctrl qdc_serial_ctrl_properties u_qdc_serial_ctrl_properties (.*);

// file: verification/qdc_serial_ctrl_tb.sv
/*
 * Self-checking bench for qdc_serial_ctrl: frames, load strobe, clear, clamp, port and bus.
 * Assumes qdc_host_model and the checker are compiled first.
 */
`timescale 1ns/1ps
`include "qdc_defs.vh"
module qdc_serial_ctrl_tb;
    logic        clk = 1'b0, rst = 1'b1, outputLoadN = 1'b0, zeroOutputsN = 1'b1;
    logic        outputClampInN = 1'b1, codingSelect = 1'b1, supplyGood = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, rd;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    wire         frameSelN, sclk, serialIn, serialOut, supplyMonitorOut, outputsClamped;
    wire         portBit0Out, portBit0OeN, portBit1Out, portBit1OeN;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  portPullUpEn, s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire  [63:0] dacCodes;
    wire  [23:0] rxWord;
    logic [15:0] e [4];
    logic [1:0]  rsp;
    int          numErrors = 0, totalChecks = 0;

    // A pin nobody drives floats high through its pull-up.
    wire portBit0In = portBit0OeN ? 1'b1 : portBit0Out;
    wire portBit1In = portBit1OeN ? 1'b1 : portBit1Out;

    // Clock at 100 MHz.
    always #5 clk = ~clk;

    qdc_serial_ctrl u_qdc_serial_ctrl (.*);
    qdc_host_model u_qdc_host_model (.clk, .serialOut, .frameSelN, .sclk, .serialIn, .rxWord);

    function automatic logic [23:0] cmd(input logic r, input logic [2:0] s, input logic [1:0] c,
                                        input logic [15:0] d);
        return {r, 1'b0, s, 1'b0, c, d};
    endfunction

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        totalChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wrapUp();
        $display("checks %0d mismatches %0d", totalChecks, numErrors);
        if (numErrors == 0 && totalChecks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic timedOut();
        numErrors++;
        $display("wrong value bus answer expected 1 seen 0");
        wrapUp();
    endtask

    // Both channels offered together; each is dropped once its ready is seen.
    task automatic axiWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n == 50) timedOut();
        @(posedge clk);
    endtask

    task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 50) timedOut();
        @(posedge clk);
    endtask

    // Low pulse on the clear input or on the load strobe, which stays high afterwards.
    task automatic pulse(input bit clr);
        if (clr) zeroOutputsN <= 1'b0;
        else outputLoadN <= 1'b0;
        repeat (4) @(posedge clk);
        zeroOutputsN <= 1'b1;
        outputLoadN <= 1'b1;
        repeat (10) @(posedge clk);
    endtask

    task automatic chkOuts(input string what);
        logic [63:0] v;
        v = {e[3], e[2], e[1], e[0]};
        if (!codingSelect) v = v ^ {4{`QDC_MSB_FLIP}};
        chk(what, v, dacCodes);
    endtask

    // Main sequence.
    initial begin
        foreach (e[i]) e[i] = 16'h0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        chkOuts("reset outputs");
        u_qdc_host_model.xfer(cmd(1'b0, `QDC_SEL_DATA, 2'd1, 16'h1234), 24);
        e[1] = 16'h1234;
        chkOuts("direct load");
        u_qdc_host_model.xfer(cmd(1'b0, `QDC_SEL_DATA, 2'd1, 16'h5555), 23);
        chkOuts("short frame");
        $display("test direct done");
        outputLoadN <= 1'b1;
        u_qdc_host_model.xfer(cmd(1'b0, `QDC_SEL_DATA, 2'd0, 16'h0f0f), 24);
        u_qdc_host_model.xfer(cmd(1'b0, `QDC_SEL_DATA, 2'd3, 16'hfedc), 24);
        chkOuts("held outputs");
        axiRd(`QDC_OFF_IN0 + 8'h0c, rd, rsp);
        chk("input reg", 32'hfedc, rd);
        pulse(1'b0);
        e[0] = 16'h0f0f;
        e[3] = 16'hfedc;
        chkOuts("joint load");
        $display("test deferred done");
        u_qdc_host_model.xfer(cmd(1'b1, `QDC_SEL_DATA, 2'd1, 16'h0), 24);
        u_qdc_host_model.xfer(24'h0, 24);
        chk("readback", {8'h0, 16'h1234}, rxWord);
        codingSelect <= 1'b0;
        repeat (8) @(posedge clk);
        chkOuts("twos coding");
        codingSelect <= 1'b1;
        outputClampInN <= 1'b0;
        repeat (8) @(posedge clk);
        chk("clamped", {4{`QDC_ZERO_VOLT_CODE}}, dacCodes);
        outputClampInN <= 1'b1;
        repeat (8) @(posedge clk);
        chkOuts("after clamp");
        pulse(1'b1);
        foreach (e[i]) e[i] = `QDC_CLEAR_CODE;
        chkOuts("cleared");
        $display("test output control done");
        supplyGood <= 1'b0;
        repeat (8) @(posedge clk);
        chk("supply out", 64'h0, supplyMonitorOut);
        supplyGood <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            u_qdc_host_model.xfer(cmd(1'b0, `QDC_SEL_PORT, 2'd0, k ? 16'h5 : 16'h1), 24);
            axiRd(`QDC_OFF_PORT, rd, rsp);
            chk("port word", k ? 32'h35 : 32'h21, rd);
        end
        chk("port pins", 64'h55, {portPullUpEn, portBit1OeN, portBit0OeN, portBit1In, portBit1Out, portBit0Out});
        chk("supply back", 64'h1, supplyMonitorOut);
        $display("test port done");
        axiWr(`QDC_OFF_MODE, 32'h1, rsp);
        chk("mode resp", `QDC_RESP_OKAY, rsp);
        axiRd(`QDC_OFF_MODE, rd, rsp);
        chk("mode", 32'h1, rd);
        u_qdc_host_model.xfer(24'h0, 24);
        chk("daisy out", cmd(1'b0, `QDC_SEL_PORT, 2'd0, 16'h5), rxWord);
        axiRd(8'hf0, rd, rsp);
        chk("unmapped read", `QDC_RESP_SLVERR, rsp);
        axiWr(8'hf0, 32'h1, rsp);
        chk("unmapped write", `QDC_RESP_SLVERR, rsp);
        $display("test bus done");
        wrapUp();
    end
endmodule
